// ===== include/cmp_pkg.sv
package cmp_pkg;
   localparam int NUM_CMP = 3;
   localparam int AW = 4;
   // Register indices on the plain port
   localparam logic [3:0] OFS_CTRL1 = 4'h0;
   localparam logic [3:0] OFS_CTRL2 = 4'h1;
   localparam logic [3:0] OFS_CTRL3 = 4'h2;
   localparam logic [3:0] OFS_STAT = 4'h3;
   localparam logic [3:0] OFS_REFMODE = 4'h4;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
   // Control register fields
   localparam int B_ENABLE = 15;
   localparam int B_PIN_OE = 14;
   localparam int B_POL = 13;
   localparam int B_EVFLAG = 9;
   localparam int B_RESULT = 8;
   localparam int B_EDGE_HI = 7;
   localparam int B_EDGE_LO = 6;
   localparam int B_REF = 4;
   localparam int B_SEL_HI = 1;
   localparam int B_SEL_LO = 0;
   localparam logic [15:0] CTRL_WMASK = 16'hE2D3;
   // Status register fields
   localparam int B_IDLE_STOP = 15;
   localparam int B_EVMIRROR = 8;
   localparam int B_RESMIRROR = 0;
   localparam logic [15:0] RESET_VAL = 16'h0000;
   // Edge select codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_ANY = 2'h3;
   // Inverting input codes and the positive reference mode code
   localparam logic [1:0] SEL_PIN_B = 2'h0;
   localparam logic [1:0] SEL_PIN_C = 2'h1;
   localparam logic [1:0] SEL_PIN_D = 2'h2;
   localparam logic [1:0] SEL_INTREF = 2'h3;
   localparam logic [1:0] REFM_VREFP = 2'h3;
endpackage : cmp_pkg

// ===== logic/cmp_ctrl.sv
`timescale 1ns/1ps
//Contract
// - There are three comparators, each with its own control register, and one shared status.
// - With pin output enable set and the comparator running, the raw comparator output XOR control bit 13 drives the result pin.
// - Control bit 13 inverts the reported result when set.
// - Edge select 11 any change, 10 falling, 01 rising, 00 no event.
// - After edge select leaves 00, the first event fires on any change, later ones per select.
// - Inverting select 00 pin B, 01 pin C, 10 pin D, 11 internal reference.
// - Status bit 15 set halts all comparators in Idle; clear keeps them running.
// - Status bits 10..8 mirror the event flags of comparators 3..1.
// - Status bits 2..0 mirror the polarity-adjusted results of comparators 3..1.
// - Internal reference with reference mode 11 routes the positive reference pin.
module cmp_ctrl
   import cmp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   input wire logic idle_in,
   input wire logic [2:0] raw_cmp_in,
   output logic [2:0] cmp_on_out,
   output logic [2:0] result_pin_out,
   output logic [2:0] result_pin_oe_n_out,
   output logic [5:0] inv_sel_out,
   output logic [2:0] ref_pos_sel_out,
   output logic [2:0] trigger_out,
   output logic irq_out
);
   logic [15:0] ctrl_q [NUM_CMP];
   logic idle_stop_q;
   logic [1:0] refm_q;
   logic [2:0] sync_w;
   logic [2:0] res_q;
   logic [2:0] res_prev_q;
   logic [2:0] armed_first_q;
   logic [2:0] evflag_q;
   logic [2:0] ev_d;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic [2:0] running;
   logic [2:0] wr_ctrl;

   function automatic logic [15:0] ctrl_view(input logic [15:0] c, input logic f,
                                             input logic r);
      logic [15:0] v;
      v = c & CTRL_WMASK;
      v[B_EVFLAG] = f;
      v[B_RESULT] = r;
      return v;
   endfunction : ctrl_view

   for (genvar i = 0; i < NUM_CMP; i++)
   begin : g_sync
      cmp_sync u_sync (
         .mclk_in(mclk_in),
         .srst_in(srst_in),
         .async_in(raw_cmp_in[i]),
         .sync_out(sync_w[i])
      );
   end

   always_comb
   begin
      for (int i = 0; i < NUM_CMP; i++)
      begin
         running[i] = ctrl_q[i][B_ENABLE] && !(idle_stop_q && idle_in);
         wr_ctrl[i] = wr_in && (addr_in == OFS_CTRL1 + 4'(i));
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         for (int i = 0; i < NUM_CMP; i++)
            ctrl_q[i] <= RESET_VAL;
      end
      else
      begin
         for (int i = 0; i < NUM_CMP; i++)
            if (wr_ctrl[i])
               ctrl_q[i] <= wdata_in & CTRL_WMASK;
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         idle_stop_q <= 1'b0;
         refm_q <= 2'h0;
         irq_mask_q <= 3'h0;
      end
      else if (wr_in)
      begin
         if (addr_in == OFS_STAT)
            idle_stop_q <= wdata_in[B_IDLE_STOP];
         if (addr_in == OFS_REFMODE)
            refm_q <= wdata_in[1:0];
         if (addr_in == OFS_IRQ_MASK)
            irq_mask_q <= wdata_in[2:0];
      end
   end

   // Result tracking; a halted comparator holds its last result
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         res_q <= 3'h0;
         res_prev_q <= 3'h0;
      end
      else
      begin
         for (int i = 0; i < NUM_CMP; i++)
         begin
            if (running[i])
               res_q[i] <= sync_w[i] ^ ctrl_q[i][B_POL];
            res_prev_q[i] <= res_q[i];
         end
      end
   end

   // edge decode, first event on any change
   always_comb
   begin
      logic rise;
      logic fall;
      rise = 1'b0;
      fall = 1'b0;
      for (int i = 0; i < NUM_CMP; i++)
      begin
         rise = res_q[i] && !res_prev_q[i];
         fall = !res_q[i] && res_prev_q[i];
         case (ctrl_q[i][B_EDGE_HI:B_EDGE_LO])
            EDGE_NONE: ev_d[i] = 1'b0;
            EDGE_RISE: ev_d[i] = rise || (armed_first_q[i] && fall);
            EDGE_FALL: ev_d[i] = fall || (armed_first_q[i] && rise);
            EDGE_ANY: ev_d[i] = rise || fall;
            default: ev_d[i] = 1'b0;
         endcase
         ev_d[i] = ev_d[i] && running[i] && !evflag_q[i];
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         armed_first_q <= 3'h0;
      else
         for (int i = 0; i < NUM_CMP; i++)
            if (wr_ctrl[i] && ctrl_q[i][B_EDGE_HI:B_EDGE_LO] == EDGE_NONE
                && wdata_in[B_EDGE_HI:B_EDGE_LO] != EDGE_NONE)
               armed_first_q[i] <= 1'b1;
            else if (ev_d[i])
               armed_first_q[i] <= 1'b0;
   end

   // event flag; set wins over software clear
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         evflag_q <= 3'h0;
      else
         for (int i = 0; i < NUM_CMP; i++)
            if (ev_d[i])
               evflag_q[i] <= 1'b1;
            else if (wr_ctrl[i] && !wdata_in[B_EVFLAG])
               evflag_q[i] <= 1'b0;
   end

   // Interrupt status, write one to clear, set wins
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         irq_stat_q <= 3'h0;
      else if (wr_in && addr_in == OFS_IRQ_STAT)
         irq_stat_q <= (irq_stat_q & ~wdata_in[2:0]) | ev_d;
      else
         irq_stat_q <= irq_stat_q | ev_d;
   end

   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         irq_out <= 1'b0;
         trigger_out <= 3'h0;
         cmp_on_out <= 3'h0;
         result_pin_out <= 3'h0;
         result_pin_oe_n_out <= 3'h7;
         inv_sel_out <= 6'h00;
         ref_pos_sel_out <= 3'h0;
      end
      else
      begin
         irq_out <= |(irq_stat_q & irq_mask_q);
         trigger_out <= ev_d;
         for (int i = 0; i < NUM_CMP; i++)
         begin
            cmp_on_out[i] <= running[i];
            // pin drive; registered unsynchronised raw output XOR the polarity bit
            result_pin_out[i] <= raw_cmp_in[i] ^ ctrl_q[i][B_POL];
            result_pin_oe_n_out[i] <= !(ctrl_q[i][B_PIN_OE] && running[i]);
            inv_sel_out[2*i +: 2] <= ctrl_q[i][B_SEL_HI:B_SEL_LO];
            ref_pos_sel_out[i] <= ctrl_q[i][B_SEL_HI:B_SEL_LO] == SEL_INTREF
                                  && refm_q == REFM_VREFP;
         end
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
         rdata_out <= 16'h0000;
      else if (rd_in)
         case (addr_in)
            OFS_CTRL1: rdata_out <= ctrl_view(ctrl_q[0], evflag_q[0], res_q[0]);
            OFS_CTRL2: rdata_out <= ctrl_view(ctrl_q[1], evflag_q[1], res_q[1]);
            OFS_CTRL3: rdata_out <= ctrl_view(ctrl_q[2], evflag_q[2], res_q[2]);
            OFS_STAT: rdata_out <= {idle_stop_q, 4'h0, evflag_q, 5'h00, res_q};
            OFS_REFMODE: rdata_out <= {14'h0000, refm_q};
            OFS_IRQ_STAT: rdata_out <= {13'h0000, irq_stat_q};
            OFS_IRQ_MASK: rdata_out <= {13'h0000, irq_mask_q};
            default: rdata_out <= 16'h0000;
         endcase
      else
         rdata_out <= 16'h0000;
   end

   evflag_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      evflag_q[0] && !wr_ctrl[0] |=> evflag_q[0]) else $error("flag dropped");
   trig_block_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      evflag_q[1] && $past(evflag_q[1]) |-> !trigger_out[1])
      else $error("trigger while flagged");
   // flag and trigger follow an event
   flag_set_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      ev_d[0] |=> evflag_q[0] && trigger_out[0]) else $error("flag not set");
   edge_none_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      ctrl_q[0][B_EDGE_HI:B_EDGE_LO] == EDGE_NONE |=> !trigger_out[0])
      else $error("event with none");
   // rising select ignores fall once armed off
   edge_rise_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      ctrl_q[2][B_EDGE_HI:B_EDGE_LO] == EDGE_RISE && !armed_first_q[2] && ev_d[2] |-> res_q[2])
      else $error("wrong edge");
   // first event after arming takes any change
   first_any_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      ctrl_q[0][B_EDGE_HI:B_EDGE_LO] == EDGE_FALL && armed_first_q[0] && running[0]
      && !evflag_q[0] && res_q[0] && !res_prev_q[0] |=> trigger_out[0])
      else $error("first event lost");
   ev_mirror_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      rd_in && addr_in == OFS_STAT |=> rdata_out[B_EVMIRROR +: 3] == $past(evflag_q)
      && rdata_out[B_RESMIRROR +: 3] == $past(res_q)) else $error("status mirror wrong");
   idle_halt_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      idle_stop_q && idle_in |=> !cmp_on_out[0] && !cmp_on_out[1]) else $error("ran in idle");
   disable_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      !running[1] |=> res_q[1] == $past(res_q[1])) else $error("result moved");
   pin_oe_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      !ctrl_q[2][B_PIN_OE] |=> result_pin_oe_n_out[2]) else $error("pin driven");
   pol_map_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      running[0] && $stable(ctrl_q[0])
      |=> res_q[0] == ($past(sync_w[0]) ^ $past(ctrl_q[0][B_POL]))) else $error("polarity wrong");
   inv_route_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      ctrl_q[2][B_SEL_HI:B_SEL_LO] == SEL_PIN_D |=> inv_sel_out[5:4] == SEL_PIN_D)
      else $error("inverting route wrong");
   ref_route_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      ctrl_q[1][B_SEL_HI:B_SEL_LO] == SEL_INTREF && refm_q == REFM_VREFP
      |=> ref_pos_sel_out[1]) else $error("reference pin not routed");
   // Interrupt level follows masked status both ways
   irq_lvl_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      |(irq_stat_q & irq_mask_q) |=> irq_out) else $error("irq missing");
   irq_low_a: assert property (@(posedge mclk_in) disable iff (srst_in)
      !(|(irq_stat_q & irq_mask_q)) |=> !irq_out) else $error("irq stuck");

   ev_cover_c: cover property (@(posedge mclk_in) ev_d[0]);
   clr_cover_c: cover property (@(posedge mclk_in) evflag_q[1] ##1 !evflag_q[1]);
   idle_cover_c: cover property (@(posedge mclk_in) idle_stop_q && idle_in);
   first_cover_c: cover property (@(posedge mclk_in) armed_first_q[0] && ev_d[0]);
   irq_cover_c: cover property (@(posedge mclk_in) irq_out);
endmodule : cmp_ctrl

// ===== logic/cmp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one comparator result
module cmp_sync
   import cmp_pkg::*;
(
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   always_ff @(posedge mclk_in)
   begin
      if (srst_in)
      begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : cmp_sync

// ===== sim/triple_comparator_event_control_tb.sv
`timescale 1ns/1ps
module triple_comparator_event_control_tb
   import cmp_pkg::*;
;
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic idle_in = 1'b0;
   logic rd_q = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000;
   logic [2:0] raw_cmp_in = 3'h0;
   logic [15:0] rdata_out;
   logic [2:0] cmp_on_out;
   logic [2:0] result_pin_out;
   logic [2:0] result_pin_oe_n_out;
   logic [2:0] ref_pos_sel_out;
   logic [2:0] trigger_out;
   logic [5:0] inv_sel_out;
   logic irq_out;
   logic [31:0] s;
   logic [15:0] expq[$];
   int mismatches = 0;
   int num_checks = 0;
   int seed = 32'h6B89;
   int trig = 0;

   cmp_ctrl dut (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .idle_in(idle_in),
      .raw_cmp_in(raw_cmp_in),
      .cmp_on_out(cmp_on_out),
      .result_pin_out(result_pin_out),
      .result_pin_oe_n_out(result_pin_oe_n_out),
      .inv_sel_out(inv_sel_out),
      .ref_pos_sel_out(ref_pos_sel_out),
      .trigger_out(trigger_out),
      .irq_out(irq_out)
   );

   task automatic chk(input string n, input logic [15:0] sv, input logic [15:0] e);
      num_checks++;
      if (sv !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, sv);
      end
   endtask : chk

   task test_done;
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   task cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : cyc

   // Extra edges let registered outputs such as irq settle before checks
   task wr(input logic [3:0] a, input logic [15:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      cyc(3);
   endtask : wr

   task rd(input logic [3:0] a, input logic [15:0] e);
      addr_in <= a;
      rd_in <= 1'b1;
      expq.push_back(e);
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(posedge mclk_in);
   endtask : rd

   // Covers the sync, edge and flag stages of the raw path
   task ev(input logic v, input int n);
      raw_cmp_in[0] <= v;
      cyc(8);
      chk("trigger count", 16'(trig), 16'(n));
   endtask : ev

   initial
   begin
      forever #25 mclk_in = ~mclk_in;
   end

   always @(posedge mclk_in)
      rd_q <= rd_in;

   // Outputs are looked at mid-cycle, away from the edge that launches them
   always @(negedge mclk_in)
   begin
      if (trigger_out[0] === 1'b1)
         trig <= trig + 1;
      if (rd_q === 1'b1)
         chk("rdata", rdata_out, expq.pop_front());
   end

   initial
   begin
      #150000;
      mismatches++;
      test_done();
   end

   initial
   begin
      repeat (5) @(posedge mclk_in);
      srst_in <= 1'b0;
      cyc(2);
      chk("oe_n", 16'(result_pin_oe_n_out), 16'h0007);
      for (int a = 0; a < 8; a++)
         rd(4'(a), 16'h0000);
      wr(OFS_CTRL1, 16'hC040);
      chk("on", 16'(cmp_on_out), 16'h0001);
      chk("oe_n", 16'(result_pin_oe_n_out), 16'h0006);
      ev(1'b1, 1);
      rd(OFS_STAT, 16'h0101);
      rd(OFS_CTRL1, 16'hC340);
      chk("pin", 16'(result_pin_out), 16'h0001);
      ev(1'b0, 1);
      rd(OFS_CTRL1, 16'hC240);
      wr(OFS_CTRL1, 16'hC040);
      ev(1'b1, 2);
      wr(OFS_CTRL1, 16'hC040);
      ev(1'b0, 2);
      chk("irq", 16'(irq_out), 16'h0000);
      wr(OFS_IRQ_MASK, 16'h0001);
      chk("irq", 16'(irq_out), 16'h0001);
      rd(OFS_IRQ_STAT, 16'h0001);
      wr(OFS_IRQ_STAT, 16'h0001);
      chk("irq", 16'(irq_out), 16'h0000);
      wr(OFS_CTRL1, 16'hC000);
      wr(OFS_CTRL1, 16'hC080);
      ev(1'b1, 3);
      wr(OFS_CTRL1, 16'hC080);
      ev(1'b0, 4);
      wr(OFS_CTRL1, 16'hC080);
      ev(1'b1, 4);
      wr(OFS_CTRL1, 16'hC0C0);
      ev(1'b0, 5);
      wr(OFS_CTRL1, 16'hC000);
      ev(1'b1, 5);
      wr(OFS_CTRL1, 16'hE000);
      rd(OFS_STAT, 16'h0000);
      chk("pin", 16'(result_pin_out), 16'h0000);
      ev(1'b0, 5);
      rd(OFS_STAT, 16'h0001);
      wr(OFS_STAT, 16'h8000);
      idle_in <= 1'b1;
      cyc(3);
      chk("on", 16'(cmp_on_out), 16'h0000);
      rd(OFS_STAT, 16'h8001);
      wr(OFS_STAT, 16'h0000);
      chk("on", 16'(cmp_on_out), 16'h0001);
      idle_in <= 1'b0;
      wr(OFS_REFMODE, 16'h0003);
      rd(OFS_REFMODE, 16'h0003);
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_CTRL2, 16'h8000 | 16'(k));
         chk("sel2", 16'(inv_sel_out[3:2]), 16'(k));
         chk("ref2", 16'(ref_pos_sel_out[1]), 16'(k == 3));
      end
      repeat (6)
      begin
         s = $random(seed);
         raw_cmp_in[2:1] <= s[3:2];
         wr(OFS_CTRL3, {14'h2000, s[1:0]});
         chk("sel3", 16'(inv_sel_out[5:4]), 16'(s[1:0]));
         chk("ref3", 16'(ref_pos_sel_out[2]), 16'(&s[1:0]));
         chk("pin3", 16'(result_pin_out[2:1]), 16'(s[3:2]));
         rd(OFS_STAT, {13'h0000, s[3:2], 1'b1});
      end
      cyc(2);
      test_done();
   end
endmodule : triple_comparator_event_control_tb
